/* common/axh_consts.svh */
`ifndef AXH_CONSTS_SVH
`define AXH_CONSTS_SVH
// Overview of operation
// - mode code 2 passive, 3 active
// - reference input must be interrupt capable
// - reference inputs filtered, default 6.4 ms
// - auto-reverse brakes at normal deceleration, reverses
// - auto-reverse needs limits enabled, active only
// - no auto-reverse: abort, error, emergency brake
// - approach direction sets search and homing direction
// - active homing uses configured switch side
// - passive homing: no motion, side from table
// - search at approach velocity within limits
// - final approach at reduced velocity within limits
// - nonzero offset moved at reduced velocity
// - offset reached: load absolute reference position
// - offset limited to plus/minus 1.0e12
// - active start aborts motion, passive does not

// ----------------------------------------
// timing
// ----------------------------------------
`define AXH_CLK_MHZ 250.0
`define AXH_FILT_TIME_MS 6.4
`define AXH_RAMP_LAST 8'hFF

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AXH_ADDR_CMD 8'h00
`define AXH_ADDR_CFG 8'h04
`define AXH_ADDR_FILT 8'h08
`define AXH_ADDR_VAPP 8'h0C
`define AXH_ADDR_VRED 8'h10
`define AXH_ADDR_VSS 8'h14
`define AXH_ADDR_VMAX 8'h18
`define AXH_ADDR_DEC 8'h1C
`define AXH_ADDR_EDEC 8'h20
`define AXH_ADDR_OFFS 8'h24
`define AXH_ADDR_POSREF 8'h28
`define AXH_ADDR_POS 8'h2C
`define AXH_ADDR_STAT 8'h30
`define AXH_ADDR_IRQ 8'h34
`define AXH_ADDR_MASK 8'h38

// ----------------------------------------
// fields and codes
// ----------------------------------------
`define AXH_MODE_PASSIVE 3'h2
`define AXH_MODE_ACTIVE 3'h3
`define AXH_CFG_APPR 0
`define AXH_CFG_SIDE 1
`define AXH_CFG_AREV 2
`define AXH_CFG_LIMEN 3
`define AXH_CFG_SEL 5:4
`define AXH_REF_CAPABLE 4'h7
`define AXH_IRQ_DONE 0
`define AXH_IRQ_ERR 1
`define AXH_IRQ_REFUSE 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define AXH_RST_CFG 8'h01
`define AXH_RST_VAPP 16'h0400
`define AXH_RST_VRED 16'h0080
`define AXH_RST_VSS 16'h0010
`define AXH_RST_VMAX 16'h8000
`define AXH_RST_DEC 16'h0010
`define AXH_RST_EDEC 16'h0100
`endif

/* common/axh_pkg.sv */
package axh_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PASSIVE, ST_SEARCH, ST_BRAKE, ST_CLEAR, ST_APPROACH, ST_OFFSET, ST_ESTOP
  } axh_state_t;
endpackage

/* rtl/axh_filt.sv */
`timescale 1ns/100ps
`default_nettype none
module axh_filt (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pin and settle time in cycles
  input wire logic din,
  input wire logic [23:0] limit,
  // filtered level
  output logic dout
);
  logic s1_r, s2_r;
  logic [23:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 24'h000000;
      dout <= 1'b0;
    end else if (s2_r == dout) begin
      cnt_r <= 24'h000000;
    end else if (cnt_r >= limit) begin
      dout <= s2_r;
      cnt_r <= 24'h000000;
    end else begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_filt_settle: assert property ($changed(dout) |-> $past(cnt_r) >= $past(limit))
    else $error("filter output changed before settle time");
endmodule // axh_filt
`default_nettype wire

/* rtl/axh_seq.sv */
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "axh_consts.svh"
module axh_seq #(
  parameter int unsigned FILT_CYCLES = int'(`AXH_FILT_TIME_MS * 1000.0 * `AXH_CLK_MHZ)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switches
  input wire logic [3:0] ref_in,
  input wire logic lim_neg_in,
  input wire logic lim_pos_in,
  // motion commanded elsewhere
  input wire logic ext_step,
  input wire logic ext_dir,
  // drive and status
  output logic step_out,
  output logic dir_out,
  output logic motion_abort,
  output logic homed,
  output logic irq
);
  axh_pkg::axh_state_t state_r;
  logic [7:0] cfg_r;
  logic [23:0] filt_r;
  logic [15:0] vapp_r, vred_r, vss_r, vmax_r, dec_r, edec_r, vel_r;
  logic [31:0] offs_r, posref_r, pos_r, rem_r;
  logic [2:0] st_r, mask_r, ev;
  logic [16:0] acc_r;
  logic [7:0] ramp_r;
  logic sdir_r, ref_d_r;
  logic limn1_r, limn2_r, limp1_r, limp2_r;
  logic [3:0] ref_flt;

  // ----------------------------------------
  // reference switch filters
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flt
      axh_filt u_flt (
        .pclk(pclk),
        .presetn(presetn),
        .din(ref_in[gi]),
        .limit(filt_r),
        .dout(ref_flt[gi])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limn1_r <= 1'b0;
      limn2_r <= 1'b0;
      limp1_r <= 1'b0;
      limp2_r <= 1'b0;
    end else begin
      limn1_r <= lim_neg_in;
      limn2_r <= limn1_r;
      limp1_r <= lim_pos_in;
      limp2_r <= limp1_r;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_en, rd_setup, mapped, cmd_wr, cfg_ok, vin_ok, refuse;
  logic start_act, start_pas;
  logic [31:0] rd_val;
  logic [15:0] vin;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign vin = pwdata[15:0];
  assign cmd_wr = wr_en && (paddr == `AXH_ADDR_CMD);
  assign start_act = cmd_wr && (pwdata[2:0] == `AXH_MODE_ACTIVE);
  assign start_pas = cmd_wr && (pwdata[2:0] == `AXH_MODE_PASSIVE);
  assign cfg_ok = |(`AXH_REF_CAPABLE & (4'h1 << pwdata[`AXH_CFG_SEL]));
  assign vin_ok = (vin >= vss_r) && (vin <= vmax_r);
  assign refuse = (cmd_wr && !start_act && !start_pas)
    || (wr_en && (paddr == `AXH_ADDR_CFG) && !cfg_ok)
    || (wr_en && ((paddr == `AXH_ADDR_VAPP) || (paddr == `AXH_ADDR_VRED)) && !vin_ok);

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    if (paddr == `AXH_ADDR_CMD) begin
      rd_val = 32'h00000000;
    end else if (paddr == `AXH_ADDR_CFG) begin
      rd_val = {24'h000000, cfg_r};
    end else if (paddr == `AXH_ADDR_FILT) begin
      rd_val = {8'h00, filt_r};
    end else if (paddr == `AXH_ADDR_VAPP) begin
      rd_val = {16'h0000, vapp_r};
    end else if (paddr == `AXH_ADDR_VRED) begin
      rd_val = {16'h0000, vred_r};
    end else if (paddr == `AXH_ADDR_VSS) begin
      rd_val = {16'h0000, vss_r};
    end else if (paddr == `AXH_ADDR_VMAX) begin
      rd_val = {16'h0000, vmax_r};
    end else if (paddr == `AXH_ADDR_DEC) begin
      rd_val = {16'h0000, dec_r};
    end else if (paddr == `AXH_ADDR_EDEC) begin
      rd_val = {16'h0000, edec_r};
    end else if (paddr == `AXH_ADDR_OFFS) begin
      rd_val = offs_r;
    end else if (paddr == `AXH_ADDR_POSREF) begin
      rd_val = posref_r;
    end else if (paddr == `AXH_ADDR_POS) begin
      rd_val = pos_r;
    end else if (paddr == `AXH_ADDR_STAT) begin
      rd_val = {25'h0, ref_flt[cfg_r[`AXH_CFG_SEL]], sdir_r, homed, 4'(state_r)};
    end else if (paddr == `AXH_ADDR_IRQ) begin
      rd_val = {29'h00000000, st_r};
    end else if (paddr == `AXH_ADDR_MASK) begin
      rd_val = {29'h00000000, mask_r};
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  // read data latched in the setup cycle so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `AXH_RST_CFG;
      filt_r <= 24'(FILT_CYCLES);
      vapp_r <= `AXH_RST_VAPP;
      vred_r <= `AXH_RST_VRED;
      vss_r <= `AXH_RST_VSS;
      vmax_r <= `AXH_RST_VMAX;
      dec_r <= `AXH_RST_DEC;
      edec_r <= `AXH_RST_EDEC;
      offs_r <= 32'h00000000;
      posref_r <= 32'h00000000;
      mask_r <= 3'h0;
    end else if (wr_en) begin
      if (paddr == `AXH_ADDR_CFG && cfg_ok) begin
        cfg_r <= pwdata[7:0];
      end else if (paddr == `AXH_ADDR_FILT) begin
        filt_r <= pwdata[23:0];
      end else if (paddr == `AXH_ADDR_VAPP && vin_ok) begin
        vapp_r <= vin;
      end else if (paddr == `AXH_ADDR_VRED && vin_ok) begin
        vred_r <= vin;
      end else if (paddr == `AXH_ADDR_VSS) begin
        vss_r <= vin;
      end else if (paddr == `AXH_ADDR_VMAX) begin
        vmax_r <= vin;
      end else if (paddr == `AXH_ADDR_DEC) begin
        dec_r <= vin;
      end else if (paddr == `AXH_ADDR_EDEC) begin
        edec_r <= vin;
      // every 32-bit offset is inside the range
      end else if (paddr == `AXH_ADDR_OFFS) begin
        offs_r <= pwdata;
      end else if (paddr == `AXH_ADDR_POSREF) begin
        posref_r <= pwdata;
      end else if (paddr == `AXH_ADDR_MASK) begin
        mask_r <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // edge selection
  // ----------------------------------------
  logic ref_f, rise, fall, hdir, side, arev_ok, lim_hit, want_rise, home_edge;
  logic pas_right, pas_edge, moving, load_now, tick, offs_zero;

  assign ref_f = ref_flt[cfg_r[`AXH_CFG_SEL]];
  assign rise = ref_f && !ref_d_r;
  assign fall = !ref_f && ref_d_r;
  // approach direction is the homing direction
  assign hdir = cfg_r[`AXH_CFG_APPR];
  assign side = cfg_r[`AXH_CFG_SIDE];
  assign arev_ok = cfg_r[`AXH_CFG_AREV] && cfg_r[`AXH_CFG_LIMEN];
  assign lim_hit = sdir_r ? limp2_r : limn2_r;
  // side picks the edge met in homing direction
  assign want_rise = side ^ hdir;
  assign home_edge = want_rise ? rise : fall;
  // side from approach, switch side and travel direction
  assign pas_right = hdir ^ side ^ ext_dir;
  assign pas_edge = (pas_right ^ ext_dir) ? rise : fall;
  assign offs_zero = (offs_r == 32'h00000000);
  assign tick = (ramp_r == `AXH_RAMP_LAST);
  assign moving = (state_r != axh_pkg::ST_IDLE) && (state_r != axh_pkg::ST_PASSIVE);
  // load point of each sequence
  // passive loads on the filtered edge alone: outside steps are single pulses
  // and seldom meet the delayed edge, so waiting for both would miss it
  assign load_now = (state_r == axh_pkg::ST_APPROACH && home_edge && offs_zero)
    || (state_r == axh_pkg::ST_OFFSET && step_out && rem_r == 32'h00000001)
    || (state_r == axh_pkg::ST_PASSIVE && pas_edge);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_r <= 1'b0;
      ramp_r <= 8'h00;
    end else begin
      ref_d_r <= ref_f;
      ramp_r <= ramp_r + 8'h01;
    end
  end

  // ----------------------------------------
  // homing sequencer
  // ----------------------------------------
  logic to_err;
  assign to_err = (state_r == axh_pkg::ST_SEARCH || state_r == axh_pkg::ST_CLEAR
    || state_r == axh_pkg::ST_APPROACH || state_r == axh_pkg::ST_OFFSET)
    && lim_hit && !arev_ok && !start_act && !start_pas;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= axh_pkg::ST_IDLE;
      sdir_r <= 1'b1;
      vel_r <= 16'h0000;
      rem_r <= 32'h00000000;
    end else if (start_act) begin
      state_r <= axh_pkg::ST_SEARCH;
      sdir_r <= hdir;
      vel_r <= vapp_r;
    end else if (start_pas) begin
      state_r <= axh_pkg::ST_PASSIVE;
      vel_r <= 16'h0000;
    end else begin
      case (state_r)
        axh_pkg::ST_PASSIVE: begin
          if (load_now) begin
            state_r <= axh_pkg::ST_IDLE;
          end
        end
        axh_pkg::ST_SEARCH, axh_pkg::ST_CLEAR, axh_pkg::ST_APPROACH,
        axh_pkg::ST_OFFSET: begin
          if (lim_hit) begin
            state_r <= arev_ok ? axh_pkg::ST_BRAKE : axh_pkg::ST_ESTOP;
          end else if (state_r == axh_pkg::ST_SEARCH) begin
            if (ref_f) begin
              vel_r <= vred_r;
              state_r <= want_rise ? axh_pkg::ST_CLEAR : axh_pkg::ST_APPROACH;
              sdir_r <= want_rise ? !hdir : hdir;
            end
          end else if (state_r == axh_pkg::ST_CLEAR) begin
            if (!ref_f) begin
              state_r <= axh_pkg::ST_APPROACH;
              sdir_r <= hdir;
            end
          end else if (state_r == axh_pkg::ST_APPROACH) begin
            if (load_now) begin
              state_r <= axh_pkg::ST_IDLE;
              vel_r <= 16'h0000;
            end else if (home_edge) begin
              state_r <= axh_pkg::ST_OFFSET;
              sdir_r <= !offs_r[31];
              rem_r <= offs_r[31] ? (32'h00000000 - offs_r) : offs_r;
            end
          end else begin
            if (load_now) begin
              state_r <= axh_pkg::ST_IDLE;
              vel_r <= 16'h0000;
            end else if (step_out) begin
              rem_r <= rem_r - 32'h00000001;
            end
          end
        end
        axh_pkg::ST_BRAKE: begin
          if (vel_r == 16'h0000) begin
            state_r <= axh_pkg::ST_SEARCH;
            sdir_r <= !sdir_r;
            vel_r <= vapp_r;
          end else if (tick) begin
            vel_r <= (vel_r > dec_r) ? vel_r - dec_r : 16'h0000;
          end
        end
        axh_pkg::ST_ESTOP: begin
          if (vel_r == 16'h0000) begin
            state_r <= axh_pkg::ST_IDLE;
          end else if (tick) begin
            vel_r <= (vel_r > edec_r) ? vel_r - edec_r : 16'h0000;
          end
        end
        default: begin
          state_r <= axh_pkg::ST_IDLE;
          vel_r <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pulse generator and position
  // ----------------------------------------
  logic [16:0] acc_nxt;
  assign acc_nxt = {1'b0, acc_r[15:0]} + {1'b0, vel_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 17'h00000;
      step_out <= 1'b0;
      dir_out <= 1'b1;
    end else begin
      acc_r <= moving ? acc_nxt : 17'h00000;
      step_out <= moving && acc_nxt[16] && !step_out;
      dir_out <= sdir_r;
    end
  end

  // own steps counted with the direction that went out beside them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= 32'h00000000;
    end else if (load_now) begin
      pos_r <= posref_r;
    end else if (step_out) begin
      pos_r <= dir_out ? pos_r + 32'h00000001 : pos_r - 32'h00000001;
    end else if (ext_step) begin
      pos_r <= ext_dir ? pos_r + 32'h00000001 : pos_r - 32'h00000001;
    end
  end

  // ----------------------------------------
  // status, abort and interrupt
  // ----------------------------------------
  // active start aborts other motion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_abort <= 1'b0;
    end else begin
      motion_abort <= start_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homed <= 1'b0;
    end else if (load_now) begin
      homed <= 1'b1;
    end else if (to_err) begin
      homed <= 1'b0;
    end
  end

  assign ev = {refuse, to_err, load_now};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= 3'h0;
    end else if (wr_en && paddr == `AXH_ADDR_IRQ) begin
      st_r <= (st_r & ~pwdata[2:0]) | ev;
    end else begin
      st_r <= st_r | ev;
    end
  end

  assign irq = |(st_r & mask_r);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_bad_cmd;
    cmd_wr && !start_act && !start_pas && state_r == axh_pkg::ST_IDLE;
  endsequence
  sequence seq_lim_abort;
    state_r == axh_pkg::ST_SEARCH && lim_hit && !arev_ok && !cmd_wr;
  endsequence

  chk_mode_refused: assert property (seq_bad_cmd |=> state_r == axh_pkg::ST_IDLE && st_r[2])
    else $error("bad mode code started homing");
  chk_cfg_sel_keep: assert property (wr_en && paddr == `AXH_ADDR_CFG && !cfg_ok
    |=> $stable(cfg_r))
    else $error("non-capable reference input accepted");
  chk_rev_brake: assert property (state_r == axh_pkg::ST_BRAKE && tick && vel_r > dec_r
    && !cmd_wr |=> vel_r == $past(vel_r) - $past(dec_r))
    else $error("reversal braking not at normal deceleration");
  chk_rev_gate: assert property ($rose(state_r == axh_pkg::ST_BRAKE) |-> $past(arev_ok))
    else $error("reversal without limits enabled");
  chk_lim_abort: assert property (seq_lim_abort |=> state_r == axh_pkg::ST_ESTOP
    && st_r[1] && !homed)
    else $error("limit without reversal did not abort");
  chk_search_vel: assert property (state_r == axh_pkg::ST_SEARCH |-> vel_r == vapp_r
    || $past(state_r) == axh_pkg::ST_BRAKE)
    else $error("search not at approach velocity");
  chk_reduced_vel: assert property (state_r == axh_pkg::ST_OFFSET
    || state_r == axh_pkg::ST_APPROACH |-> vel_r == vred_r || $past(wr_en))
    else $error("final approach not at reduced velocity");
  chk_pos_load: assert property (load_now && !cmd_wr
    |=> pos_r == $past(posref_r) && homed ##1 st_r[0])
    else $error("reference position not loaded");
  chk_active_abort: assert property (start_act |=> motion_abort ##1 !motion_abort)
    else $error("active start did not abort motion");
  chk_passive_still: assert property (state_r == axh_pkg::ST_PASSIVE |-> !step_out
    || $past(moving))
    else $error("passive homing drove steps");
endmodule // axh_seq
`default_nettype wire

/* dv/axh_drive_model.sv */
`timescale 1ns/100ps
`default_nettype none
module axh_drive_model #(
  parameter int REF_LO = 40,
  parameter int REF_HI = 60,
  parameter int LIM_N = -20,
  parameter int LIM_P = 400
) (
  // clock
  input wire logic pclk,
  // step pulses from the block and from other motion logic
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic ext_step,
  input wire logic ext_dir,
  // switches
  output logic [3:0] ref_in,
  output logic lim_neg_in,
  output logic lim_pos_in,
  // physical axis position
  output var int pos
);
  logic tog = 1'b0;
  initial pos = 0;
  // ----------------
  // axis and switches
  // ----------------
  always @(posedge pclk) begin
    tog <= ~tog;
    if (step_out)
      pos <= pos + (dir_out ? 1 : -1);
    else if (ext_step)
      pos <= pos + (ext_dir ? 1 : -1);
  end
  // band outlasts filter
  // unused inputs chatter every cycle so no filter with a nonzero settle time can settle them
  assign ref_in = {{3{tog}}, pos >= REF_LO && pos <= REF_HI};
  assign lim_neg_in = pos <= LIM_N;
  assign lim_pos_in = pos >= LIM_P;
endmodule // axh_drive_model
`default_nettype wire

/* dv/axis_homing_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "axh_consts.svh"
module axis_homing_sequencer_bench;
  // ----------------
  // signals
  // ----------------
  localparam int FC = 4;
  localparam int RL = 40;
  localparam int RH = 60;
  localparam logic [7:0] RA [8] = '{`AXH_ADDR_CFG, `AXH_ADDR_FILT, `AXH_ADDR_VAPP,
    `AXH_ADDR_VRED, `AXH_ADDR_VSS, `AXH_ADDR_VMAX, `AXH_ADDR_DEC, `AXH_ADDR_EDEC};
  localparam logic [31:0] RV [8] = '{32'(`AXH_RST_CFG), 32'(FC), 32'(`AXH_RST_VAPP),
    32'(`AXH_RST_VRED), 32'(`AXH_RST_VSS), 32'(`AXH_RST_VMAX), 32'(`AXH_RST_DEC),
    32'(`AXH_RST_EDEC)};
  localparam logic [7:0] TA [5] = '{`AXH_ADDR_CFG, `AXH_ADDR_VAPP, `AXH_ADDR_VRED,
    `AXH_ADDR_VRED, `AXH_ADDR_VAPP};
  localparam logic [31:0] TD [5] = '{32'h30, 32'hF, 32'h8001, 32'h10, 32'h8000};
  localparam logic [31:0] TE [5] = '{32'h1, 32'h400, 32'h80, 32'h10, 32'h8000};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, ref_pos;
  logic [31:0] rnd = 32'h5271;
  logic pready, pslverr, step_out, dir_out, motion_abort, homed, irq, e;
  logic ext_step = 1'b0;
  logic ext_dir = 1'b0;
  logic lim_neg_in, lim_pos_in;
  logic [3:0] ref_in;
  int pos, p0, base;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_step = 0;
  int n_abort = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    n_step <= n_step + int'(step_out);
    n_abort <= n_abort + int'(motion_abort);
  end
  axh_seq #(.FILT_CYCLES(FC)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_in(ref_in), .lim_neg_in(lim_neg_in),
    .lim_pos_in(lim_pos_in), .ext_step(ext_step), .ext_dir(ext_dir), .step_out(step_out),
    .dir_out(dir_out), .motion_abort(motion_abort), .homed(homed), .irq(irq));
  axh_drive_model #(.REF_LO(RL), .REF_HI(RH)) drv (.pclk(pclk), .step_out(step_out),
    .dir_out(dir_out), .ext_step(ext_step), .ext_dir(ext_dir), .ref_in(ref_in),
    .lim_neg_in(lim_neg_in), .lim_pos_in(lim_pos_in), .pos(pos));
  // ----------------
  // tasks
  // ----------------
  task automatic summarize;
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic fail;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    summarize();
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // the master never counts on zero wait states
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fail();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
      fail();
  endtask
  task automatic ext_move(input int target);
    int n;
    n = 0;
    ext_dir <= target > pos;
    while (pos != target && n < 400) begin
      ext_step <= 1'b1;
      @(posedge pclk);
      ext_step <= 1'b0;
      repeat (15) @(posedge pclk);
      n++;
    end
    if (n >= 400)
      fail();
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rd(RA[i]);
      check(q, RV[i]);
    end
    rd(8'h3C);
    check(32'(e), 32'h1);
    wr(`AXH_ADDR_MASK, 32'h0);
    for (int m = 0; m < 8; m++) begin
      if (m == 2 || m == 3)
        continue;
      wr(`AXH_ADDR_CMD, 32'(m));
      rd(`AXH_ADDR_IRQ);
      check(q, 32'h4);
      check(32'(irq), 32'h0);
      wr(`AXH_ADDR_IRQ, 32'h4);
    end
    for (int i = 0; i < 5; i++) begin
      wr(TA[i], TD[i]);
      rd(TA[i]);
      check(q, TE[i]);
      rd(`AXH_ADDR_IRQ);
      check(q, (TD[i] == TE[i]) ? 32'h0 : 32'h4);
      wr(`AXH_ADDR_IRQ, 32'h4);
    end
    wr(`AXH_ADDR_MASK, 32'h7);
    wr(`AXH_ADDR_CMD, 32'h0);
    check(32'(irq), 32'h1);
    wr(`AXH_ADDR_IRQ, 32'h4);
    check(32'(irq), 32'h0);
    wr(`AXH_ADDR_VAPP, 32'h400);
    wr(`AXH_ADDR_VRED, 32'h80);
    rnd = xs(rnd);
    ref_pos = rnd;
    wr(`AXH_ADDR_POSREF, ref_pos);
    wr(`AXH_ADDR_OFFS, 32'h5);
    wr(`AXH_ADDR_CFG, 32'h3);
    wr(`AXH_ADDR_CMD, 32'h3);
    wait_irq(30000);
    rd(`AXH_ADDR_IRQ);
    check(q, 32'h1);
    rd(`AXH_ADDR_POS);
    check(q, ref_pos);
    check(32'(pos), 32'(RH + 6));
    check(32'(homed), 32'h1);
    check(32'(n_abort), 32'h1);
    wr(`AXH_ADDR_IRQ, 32'h7);
    // input 1 only chatters, so the search runs into the lower limit
    wr(`AXH_ADDR_CFG, 32'h18);
    wr(`AXH_ADDR_CMD, 32'h3);
    wait_irq(20000);
    p0 = pos;
    rd(`AXH_ADDR_IRQ);
    check(q, 32'h2);
    rd(`AXH_ADDR_STAT);
    check(q & 32'hF, 32'h7);
    check(32'(homed), 32'h0);
    repeat (3000) @(posedge pclk);
    check(32'(pos > p0 - 16), 32'h1);
    wr(`AXH_ADDR_IRQ, 32'h7);
    wr(`AXH_ADDR_DEC, 32'h40);
    wr(`AXH_ADDR_OFFS, 32'h0);
    rnd = xs(rnd);
    ref_pos = rnd;
    wr(`AXH_ADDR_POSREF, ref_pos);
    wr(`AXH_ADDR_CFG, 32'hC);
    wr(`AXH_ADDR_CMD, 32'h3);
    wait_irq(60000);
    rd(`AXH_ADDR_IRQ);
    check(q, 32'h1);
    rd(`AXH_ADDR_POS);
    check(q, ref_pos);
    check(32'(homed), 32'h1);
    wr(`AXH_ADDR_IRQ, 32'h7);
    ext_move(RL - 3);
    rnd = xs(rnd);
    ref_pos = rnd;
    wr(`AXH_ADDR_POSREF, ref_pos);
    wr(`AXH_ADDR_CFG, 32'h3);
    base = n_step;
    wr(`AXH_ADDR_CMD, 32'h2);
    ext_move(RH + 4);
    rd(`AXH_ADDR_IRQ);
    check(q, 32'h1);
    rd(`AXH_ADDR_POS);
    check(q, ref_pos + 32'h3);
    check(32'(n_step - base), 32'h0);
    check(32'(n_abort), 32'h3);
    wr(`AXH_ADDR_IRQ, 32'h7);
    // negative approach, right side: rising edge wanted, so the switch is cleared first
    rnd = xs(rnd);
    ref_pos = rnd;
    wr(`AXH_ADDR_POSREF, ref_pos);
    wr(`AXH_ADDR_OFFS, 32'hFFFFFFFE);
    wr(`AXH_ADDR_CFG, 32'h2);
    wr(`AXH_ADDR_CMD, 32'h3);
    wait_irq(10000);
    rd(`AXH_ADDR_IRQ);
    check(q, 32'h1);
    rd(`AXH_ADDR_POS);
    check(q, ref_pos);
    check(32'(pos), 32'(RH - 2));
    check(32'(n_abort), 32'h4);
    summarize();
  end
endmodule // axis_homing_sequencer_bench
`default_nettype wire
